// File: shared/aivr_pkg.sv
package aivr_pkg;

  // ==========================================================
  // Word layout
  localparam int unsigned WORD_W = 16;
  localparam int unsigned VAL_LSB = 3;
  localparam int unsigned ACT_BIT = 2;
  localparam int unsigned ERR_BIT = 1;
  localparam int unsigned OVF_BIT = 0;
  localparam int unsigned CNT_W = 13;
  localparam int unsigned CH_W = 4;
  localparam int unsigned NCH = 16;

  // ==========================================================
  // Count limits
  localparam logic [12:0] UNI_MAX = 13'h0fff;
  localparam logic [12:0] BIP_MAX = 13'h07ff;
  localparam logic [12:0] BIP_MIN = 13'h1800;
  localparam logic [12:0] OFF_MID = 13'h0800;
  localparam logic [12:0] LZ_BASE = 13'h0200;
  localparam logic [12:0] LZ_TOP = 13'h0a00;
  localparam logic [12:0] LZ_OVF = 13'h09ff;
  localparam logic [12:0] MAG_NEG_FULL = 13'h1800;

  // ==========================================================
  // Timing
  localparam int unsigned CLK_MHZ = 125;
  localparam int unsigned TEST_US = 1600;
  localparam int unsigned TEST_CYC = TEST_US * CLK_MHZ;
  localparam int unsigned SLOW0_US = 40000;
  localparam int unsigned SLOW_US = 60000;
  localparam int unsigned SLOW0_CYC = SLOW0_US * CLK_MHZ;
  localparam int unsigned SLOW_CYC = SLOW_US * CLK_MHZ;
  localparam int unsigned FAST_US = 250;
  localparam int unsigned FAST_CYC = FAST_US * CLK_MHZ;

  typedef enum logic [1:0] {
    AIVR_RNG_UNI, AIVR_RNG_BIP, AIVR_RNG_LZ, AIVR_RNG_RTD
  } aivr_range_t;

  typedef enum logic [1:0] {
    AIVR_FMT_TWOS, AIVR_FMT_SMAG, AIVR_FMT_OFFS
  } aivr_fmt_t;

  typedef struct packed {
    logic [CH_W-1:0] chan;
    logic [WORD_W-1:0] word;
  } aivr_result_t;

  typedef struct packed {
    logic measLine;
    logic sensor;
    logic senseLine;
    logic srcPos;
  } aivr_rtd_brk_t;

endpackage

// File: verilog/aivr_readout.sv
`timescale 1ns/1ps
`default_nettype none
// Function
// RL1: Open input sets error bit 1 and reports value zero.
// RL2: Unipolar counts 0..4095 in bits 15:3, overflow at 4095 and 0.
// RL3: Two's complement -2048..2047 sign-extended, overflow at both ends.
// RL4: Sign-magnitude: sign bit 15, magnitude 14:3; -2048 sets 15,14, overflow.
// RL5: Offset binary: zero maps to 2048, span 0..4095, overflow at ends.
// RL6: Unipolar and live-zero words ignore the bipolar format choice.
// RL7: Live zero spans 512..2560, overflow at 2559 and 0; host subtracts 512.
// RL8: Open detection for 8 or 16 inputs, or 4 or 8 in 8-channel mode.
// RL9: Test current 1.6 ms before conversion; level above limit flags open.
// RL10: External disable plus selector setting suppresses test current.
// RL11: Broken measuring line gives zero and error; sensor/sense only enhanced.
// RL12: Overflow flag kept per channel.
// RL13: Supply-monitor setting flags break in positive source line.
// RL14: Voltage/current setting ignores source-line breaks.
// RL15: Cyclic mode refreshes all channels in rotation.
// RL16: Slow variant conversion about 40 ms at zero input, else 60 ms.
// RL17: Results held per channel, high byte at n, low byte at n+1.
// RL18: Host word write to channel converts only that channel.
// RL19: One module-wide activity flag while selective conversion runs.
// RL20: Host reads result only after activity flag falls.
// RL21: Host must not double-assign input and output addresses.
// RL22: Host discards first selective value after restart.
module aivr_readout #(
  parameter int unsigned TEST_CYCLES = aivr_pkg::TEST_CYC,
  parameter int unsigned SLOW0_CYCLES = aivr_pkg::SLOW0_CYC,
  parameter int unsigned SLOW_CYCLES = aivr_pkg::SLOW_CYC,
  parameter int unsigned FAST_CYCLES = aivr_pkg::FAST_CYC
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire aivr_pkg::aivr_range_t rangeSel,
  input wire aivr_pkg::aivr_fmt_t fmtSel,
  input wire logic chan16Mode,
  input wire logic openDetWide,
  input wire logic openDetEn,
  input wire logic testCurDisablePin,
  input wire logic enhancedVariant,
  input wire logic fastVariant,
  input wire logic rtdSupplyMon,
  input wire logic voltCurMode,
  output logic testCurrentOn,
  output logic [3:0] adcChan,
  output logic adcStart,
  input wire logic adcDone,
  input wire logic [12:0] adcCount,
  input wire logic openLevelPin,
  input wire aivr_pkg::aivr_rtd_brk_t rtdBreakPins,
  input wire logic peripheral_word_write,
  input wire logic [3:0] wrChan,
  input wire logic [4:0] channel_word_location,
  output logic [7:0] rdByte,
  output logic activityFlag,
  output logic resValid,
  input wire logic resReady,
  output aivr_pkg::aivr_result_t resData
);

  // ==========================================================
  // Pin synchronisers
  logic [1:0] openSync_q;
  logic [1:0] disSync_q;
  logic [3:0] brkSync0_q;
  logic [3:0] brkSync1_q;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      openSync_q <= 2'h0;
      disSync_q <= 2'h0;
      brkSync0_q <= 4'h0;
      brkSync1_q <= 4'h0;
    end else begin
      openSync_q <= {openSync_q[0], openLevelPin};
      disSync_q <= {disSync_q[0], testCurDisablePin};
      brkSync0_q <= rtdBreakPins;
      brkSync1_q <= brkSync0_q;
    end
  end
  aivr_pkg::aivr_rtd_brk_t brk;
  assign brk = aivr_pkg::aivr_rtd_brk_t'(brkSync1_q);

  // ==========================================================
  // Sequencer
  typedef enum logic [1:0] {S_IDLE, S_TEST, S_CONV, S_STORE} aivr_st_t;
  aivr_st_t st_q;
  logic [31:0] cnt_q;
  logic [3:0] chan_q;
  logic sel_q;
  logic selPend_q;
  logic [3:0] selChan_q;
  logic openSeen_q;
  logic [12:0] count_q;

  logic [3:0] lastChan;
  logic openWatched;
  logic testSuppress;
  logic bufInReady;
  logic [31:0] convLen;
  assign lastChan = chan16Mode ? 4'hf : 4'h7;
  // Upper half of inputs only watched in wide selection
  assign openWatched = openDetEn &&
    (openDetWide || (chan_q < (chan16Mode ? 4'h8 : 4'h4))); // RL8
  assign testSuppress = disSync_q[1] && !openDetEn; // RL10
  // A level-dependent slow conversion is modelled as a time limit that adcDone can cut short
  assign convLen = fastVariant ? FAST_CYCLES :
    ((count_q == 13'h0000) ? SLOW0_CYCLES : SLOW_CYCLES); // RL16

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= S_IDLE;
      cnt_q <= 32'h0;
      chan_q <= 4'h0;
      sel_q <= 1'b0;
      selPend_q <= 1'b0;
      selChan_q <= 4'h0;
      openSeen_q <= 1'b0;
      count_q <= 13'h0;
    end else begin
      if (peripheral_word_write) begin
        selPend_q <= 1'b1; // RL18
        selChan_q <= wrChan;
      end else if (st_q == S_IDLE && selPend_q) begin
        selPend_q <= 1'b0;
      end
      unique case (st_q)
        S_IDLE: begin
          sel_q <= selPend_q;
          if (selPend_q) begin
            chan_q <= selChan_q; // RL18
          end
          cnt_q <= 32'h0;
          openSeen_q <= 1'b0;
          // Current flows on every input; the selector only masks the report
          st_q <= testSuppress ? S_CONV : S_TEST; // RL10
        end
        S_TEST: begin
          cnt_q <= cnt_q + 32'h1;
          if (openSync_q[1]) begin
            openSeen_q <= 1'b1; // RL9
          end
          if (cnt_q == TEST_CYCLES - 1) begin
            cnt_q <= 32'h0;
            st_q <= S_CONV;
          end
        end
        S_CONV: begin
          if (adcDone) begin
            count_q <= adcCount;
          end
          cnt_q <= cnt_q + 32'h1;
          if (adcDone || cnt_q >= convLen) begin
            st_q <= S_STORE;
          end
        end
        S_STORE: begin
          if (bufInReady) begin
            st_q <= S_IDLE;
            if (!sel_q) begin
              chan_q <= (chan_q == lastChan) ? 4'h0 : chan_q + 4'h1; // RL15
            end
          end
        end
      endcase
    end
  end
  assign testCurrentOn = (st_q == S_TEST); // RL9
  assign adcChan = chan_q;
  assign adcStart = (st_q == S_CONV) && (cnt_q == 32'h0);

  // ==========================================================
  // Word formatting
  logic rtdErr;
  logic errFlag;
  logic [12:0] val;
  logic [12:0] mag;
  logic [12:0] outBits;
  logic ovf;
  assign rtdErr = (rangeSel == aivr_pkg::AIVR_RNG_RTD) && (brk.measLine ||
    (enhancedVariant && (brk.sensor || brk.senseLine)) ||
    (rtdSupplyMon && !voltCurMode && brk.srcPos)); // RL11 RL13 RL14
  assign errFlag = (openSeen_q && openWatched) || rtdErr; // RL1 RL8
  assign val = errFlag ? 13'h0000 : count_q; // RL1
  assign mag = val[12] ? 13'(-val) : val;
  always_comb begin
    outBits = val;
    ovf = 1'b0;
    unique case (rangeSel)
      aivr_pkg::AIVR_RNG_BIP: begin
        unique case (fmtSel)
          aivr_pkg::AIVR_FMT_SMAG: begin
            outBits = (val == aivr_pkg::BIP_MIN) ? aivr_pkg::MAG_NEG_FULL :
              {val[12], mag[11:0]}; // RL4
          end
          aivr_pkg::AIVR_FMT_OFFS: begin
            outBits = 13'(val + aivr_pkg::OFF_MID); // RL5
          end
          default: begin
            outBits = val; // RL3
          end
        endcase
        ovf = (val == aivr_pkg::BIP_MAX) || (val == aivr_pkg::BIP_MIN); // RL3
      end
      aivr_pkg::AIVR_RNG_LZ: begin
        ovf = (val == aivr_pkg::LZ_OVF) || (val == 13'h0000); // RL7
      end
      default: begin
        ovf = (val == aivr_pkg::UNI_MAX) || (val == 13'h0000); // RL2 RL6
      end
    endcase
  end
  logic [15:0] word;
  assign word = {outBits, 1'b0, errFlag, ovf};

  // ==========================================================
  // Per-channel store and activity flag
  logic [15:0] store_q [aivr_pkg::NCH];
  logic act_q;
  logic storeFire;
  assign storeFire = (st_q == S_STORE) && bufInReady;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      act_q <= 1'b0;
      for (int i = 0; i < aivr_pkg::NCH; i++) begin
        store_q[i] <= 16'h0000;
      end
    end else begin
      if (storeFire) begin
        store_q[chan_q] <= word; // RL12 RL17
      end
      // A write in the closing cycle keeps the flag up
      act_q <= peripheral_word_write ||
        (act_q && !(storeFire && sel_q && !selPend_q)); // RL19
    end
  end
  assign activityFlag = act_q; // RL19
  logic [15:0] rdWord;
  assign rdWord = store_q[channel_word_location[4:1]];
  // Low byte carries the activity bit live, not the stored copy
  assign rdByte = channel_word_location[0] ?
    {rdWord[7:3], act_q, rdWord[1:0]} : rdWord[15:8]; // RL17

  // ==========================================================
  // Two-entry result buffer
  aivr_pkg::aivr_result_t buf_q [2];
  logic [1:0] fill_q;
  logic rdPtr_q;
  logic wrPtr_q;
  logic pushEn;
  logic popEn;
  assign bufInReady = (fill_q != 2'h2);
  assign pushEn = storeFire;
  assign popEn = resValid && resReady;
  assign resValid = (fill_q != 2'h0);
  assign resData = buf_q[rdPtr_q];
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      fill_q <= 2'h0;
      rdPtr_q <= 1'b0;
      wrPtr_q <= 1'b0;
      buf_q[0] <= '0;
      buf_q[1] <= '0;
    end else begin
      if (pushEn) begin
        buf_q[wrPtr_q] <= '{chan: chan_q, word: word};
        wrPtr_q <= !wrPtr_q;
      end
      if (popEn) begin
        rdPtr_q <= !rdPtr_q;
      end
      fill_q <= 2'(fill_q + {1'b0, pushEn} - {1'b0, popEn});
    end
  end

  // ==========================================================
  // Checks
  zero_on_open_a: assert property (@(posedge clock) // RL1
    disable iff (!rst_b)
    storeFire && openSeen_q && openWatched |-> word[1] && word[15:3] == 0)
    else $error("open input not zero with error");
  test_suppr_a: assert property (@(posedge clock) // RL10
    disable iff (!rst_b)
    testSuppress && st_q == S_IDLE |=> !testCurrentOn)
    else $error("test current not suppressed");
  act_on_write_a: assert property (@(posedge clock) // RL19
    disable iff (!rst_b)
    peripheral_word_write |=> activityFlag)
    else $error("activity flag missing");
  uni_ovf_a: assert property (@(posedge clock) // RL2
    disable iff (!rst_b)
    rangeSel == aivr_pkg::AIVR_RNG_UNI && !errFlag && count_q == 13'h0fff
    |-> word[0])
    else $error("unipolar overflow missing");
  lz_ovf_a: assert property (@(posedge clock) // RL7
    disable iff (!rst_b)
    rangeSel == aivr_pkg::AIVR_RNG_LZ && !errFlag && count_q == 13'h09ff
    |-> word[0])
    else $error("live zero overflow missing");
  smag_neg_a: assert property (@(posedge clock) // RL4
    disable iff (!rst_b)
    rangeSel == aivr_pkg::AIVR_RNG_BIP && fmtSel == aivr_pkg::AIVR_FMT_SMAG
    && !errFlag && count_q == 13'h1800 |-> word[15:14] == 2'h3 && word[0])
    else $error("sign magnitude full scale wrong");
  test_len_a: assert property (@(posedge clock) // RL9
    disable iff (!rst_b)
    $rose(testCurrentOn) |-> testCurrentOn[*8])
    else $error("test current too short");
  // A stalled receiver must see the same word until it takes it
  res_hold_a: assert property (@(posedge clock)
    disable iff (!rst_b)
    resValid && !resReady |=> resValid && $stable(resData))
    else $error("stalled result changed");

endmodule
`default_nettype wire

// File: tb/aivr_adc_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Converter stand-in
// Count bus toggles outside an answer, so early sampling shows
module aivr_adc_model (
  input wire logic clock,
  input wire logic [3:0] adcChan,
  input wire logic adcStart,
  input wire logic [15:0][12:0] counts,
  output logic adcDone,
  output logic [12:0] adcCount
);
  int waitCnt;
  logic [3:0] chanQ;
  initial begin
    adcDone = 1'b0;
    adcCount = 13'h1555;
    waitCnt = 0;
    chanQ = 4'h0;
  end
  always @(posedge clock) begin
    adcDone <= 1'b0;
    adcCount <= ~adcCount;
    if (adcStart) begin
      waitCnt <= $urandom_range(24, 1);
      chanQ <= adcChan;
    end else if (waitCnt == 1) begin
      waitCnt <= 0;
      adcDone <= 1'b1;
      adcCount <= counts[chanQ];
    end else if (waitCnt > 1) begin
      waitCnt <= waitCnt - 1;
    end
  end
endmodule
`default_nettype wire

// File: tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clock, rst_b, chan16Mode, openDetWide, openDetEn;
  logic testCurDisablePin, enhancedVariant, fastVariant;
  logic rtdSupplyMon, voltCurMode, testCurrentOn, adcStart, adcDone;
  logic openLevelPin, peripheral_word_write, activityFlag, resValid;
  logic resReady, sawTest;
  logic [3:0] adcChan, wrChan;
  logic [12:0] adcCount;
  logic [4:0] channel_word_location;
  logic [7:0] rdByte;
  logic [15:0] seen, word;
  logic [15:0][12:0] counts;
  aivr_pkg::aivr_range_t rangeSel;
  aivr_pkg::aivr_fmt_t fmtSel;
  aivr_pkg::aivr_rtd_brk_t rtdBreakPins;
  aivr_pkg::aivr_result_t resData;
  int failures, num_checks, cycles;
  logic resCheck;
  logic [12:0] cc [9] = '{13'h0000, 13'h0fff, 13'h0001, 13'h07ff,
    13'h1800, 13'h1fff, 13'h0000, 13'h09ff, 13'h0200};
  logic [6:0] ot [6] = '{7'h7d, 7'h55, 7'h4c, 7'h12, 7'h06, 7'h36};
  logic [7:0] rt [6] = '{8'h81, 8'h49, 8'h40, 8'h29, 8'h15, 8'h16};

  aivr_readout #(.TEST_CYCLES(16), .SLOW0_CYCLES(64), .SLOW_CYCLES(96),
    .FAST_CYCLES(32)) aivr_readout_i (.clock, .rst_b, .rangeSel, .fmtSel,
    .chan16Mode, .openDetWide, .openDetEn, .testCurDisablePin,
    .enhancedVariant, .fastVariant, .rtdSupplyMon, .voltCurMode,
    .testCurrentOn, .adcChan, .adcStart, .adcDone, .adcCount, .openLevelPin,
    .rtdBreakPins, .peripheral_word_write, .wrChan, .channel_word_location,
    .rdByte, .activityFlag, .resValid, .resReady, .resData);
  aivr_adc_model aivr_adc_model_i (.clock, .adcChan, .adcStart, .counts,
    .adcDone, .adcCount);

  // ==========================================================
  // Checks and expectations
  task automatic chk16(input logic [15:0] got, input logic [15:0] exp,
    input logic [15:0] m);
    num_checks++;
    if ((got & m) !== (exp & m)) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got & m, exp & m);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic [15:0] enc(input aivr_pkg::aivr_range_t r,
    input aivr_pkg::aivr_fmt_t f, input logic [12:0] c);
    logic [12:0] v;
    logic ov;
    v = c;
    ov = (c == 13'h0000);
    if (r == aivr_pkg::AIVR_RNG_UNI) begin
      ov = ov || (c == 13'h0fff);
    end else if (r == aivr_pkg::AIVR_RNG_LZ) begin
      ov = ov || (c == 13'h09ff);
    end else begin
      ov = (c == 13'h07ff) || (c == 13'h1800);
      if (f == aivr_pkg::AIVR_FMT_SMAG && c[12]) v = {1'b1, 12'(-c)};
      if (f == aivr_pkg::AIVR_FMT_OFFS) v = c + 13'h0800;
    end
    return {v, 2'b00, ov};
  endfunction
  task automatic report_and_stop;
    if (failures == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // ==========================================================
  // Selective conversion, then both bytes read back
  task automatic run(input aivr_pkg::aivr_range_t r,
    input aivr_pkg::aivr_fmt_t f, input logic [3:0] ch, input logic [12:0] c);
    int n;
    @(posedge clock);
    rangeSel <= r;
    fmtSel <= f;
    counts[ch] <= c;
    // Inputs pass two sync stages before the sequencer sees them
    repeat (4) @(posedge clock);
    peripheral_word_write <= 1'b1;
    wrChan <= ch;
    @(posedge clock);
    peripheral_word_write <= 1'b0;
    @(posedge clock);
    @(negedge clock);
    chk1(activityFlag, 1'b1);
    sawTest = 1'b0;
    n = 0;
    while (activityFlag !== 1'b0 && n < 600) begin
      sawTest |= testCurrentOn;
      @(negedge clock);
      n++;
    end
    chk1(activityFlag, 1'b0);
    @(posedge clock);
    channel_word_location <= {ch, 1'b0};
    @(negedge clock);
    word[15:8] = rdByte;
    @(posedge clock);
    channel_word_location <= {ch, 1'b1};
    @(negedge clock);
    word[7:0] = rdByte;
  endtask

  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (resValid && resReady) begin
      seen[resData.chan] <= 1'b1;
      if (resCheck) begin
        chk16(resData.word, enc(aivr_pkg::AIVR_RNG_UNI, fmtSel,
          counts[resData.chan]), 16'hffff);
      end
    end
    if (cycles == 40000) begin
      failures++;
      report_and_stop;
    end
  end

  initial begin
    aivr_pkg::aivr_range_t r;
    aivr_pkg::aivr_fmt_t fm;
    logic [12:0] c;
    {rst_b, openDetWide, openDetEn, testCurDisablePin} = 4'h4;
    {enhancedVariant, fastVariant, rtdSupplyMon, voltCurMode} = 4'h0;
    {openLevelPin, peripheral_word_write, chan16Mode, resReady} = 4'h3;
    rangeSel = aivr_pkg::AIVR_RNG_UNI;
    fmtSel = aivr_pkg::AIVR_FMT_TWOS;
    rtdBreakPins = '0;
    {wrChan, channel_word_location, counts, seen, resCheck} = '0;
    {failures, num_checks, cycles} = '0;
    void'($urandom(36849));
    repeat (8) @(posedge clock);
    rst_b <= 1'b1;
    run(rangeSel, fmtSel, 4'h0, 13'h0000);
    for (int i = 0; i < 27; i++) begin
      r = aivr_pkg::aivr_range_t'(i / 9);
      fm = aivr_pkg::aivr_fmt_t'(i % 3);
      run(r, fm, 4'($urandom_range(15)), cc[i / 3]);
      chk16(word, enc(r, fm, cc[i / 3]), 16'hffff);
    end
    for (int k = 0; k < 30; k++) begin
      r = aivr_pkg::aivr_range_t'($urandom_range(2));
      fm = aivr_pkg::aivr_fmt_t'($urandom_range(2));
      c = 13'($urandom_range(r == aivr_pkg::AIVR_RNG_LZ ? 2559 : 4095));
      if (r == aivr_pkg::AIVR_RNG_BIP) c = c - 13'h0800;
      run(r, fm, 4'($urandom_range(15)), c);
      chk16(word, enc(r, fm, c), 16'hffff);
    end
    @(posedge clock);
    {openDetEn, openLevelPin} <= 2'b11;
    for (int i = 0; i < 6; i++) begin
      @(posedge clock);
      {chan16Mode, openDetWide} <= ot[i][6:5];
      run(aivr_pkg::AIVR_RNG_UNI, fmtSel, ot[i][3:0], 13'h0123);
      if (ot[i][4]) begin
        chk16(word, 16'h0002, 16'hfffe);
        chk1(sawTest, 1'b1);
      end else begin
        chk16(word, 16'h0918, 16'hffff);
      end
    end
    @(posedge clock);
    {chan16Mode, openDetWide, testCurDisablePin} <= 3'b111;
    repeat (24) @(posedge clock);
    // Disable pin alone leaves the test current running
    run(aivr_pkg::AIVR_RNG_UNI, fmtSel, 4'h3, 13'h0123);
    chk1(sawTest, 1'b1);
    chk16(word, 16'h0002, 16'hfffe);
    @(posedge clock);
    openDetEn <= 1'b0;
    // Let a test already under way finish before watching for quiet
    repeat (24) @(posedge clock);
    run(aivr_pkg::AIVR_RNG_UNI, fmtSel, 4'h3, 13'h0123);
    chk1(sawTest, 1'b0);
    chk16(word, 16'h0918, 16'hffff);
    @(posedge clock);
    {openDetEn, openLevelPin, testCurDisablePin} <= 3'b100;
    for (int i = 0; i < 6; i++) begin
      @(posedge clock);
      {rtdBreakPins, enhancedVariant, rtdSupplyMon, voltCurMode} <= rt[i][7:1];
      run(aivr_pkg::AIVR_RNG_RTD, fmtSel, 4'h4, 13'h0123);
      chk16(word, {14'h0, rt[i][0], 1'b0}, i == 0 ? 16'hfffe : 16'h0002);
    end
    // Receiver stalls; the full buffer must hold its word, not drop it
    @(posedge clock);
    rtdBreakPins <= '0;
    {resReady, fastVariant, openDetEn} <= 3'b010;
    rangeSel <= aivr_pkg::AIVR_RNG_UNI;
    resCheck <= 1'b1;
    repeat (300) @(posedge clock);
    @(negedge clock);
    chk1(resValid, 1'b1);
    seen = '0;
    repeat (3000) begin
      @(posedge clock);
      resReady <= 1'($urandom_range(1));
    end
    chk16(seen, 16'hffff, 16'hffff);
    report_and_stop;
  end
endmodule
`default_nettype wire
